//--- rtl/tcr_timer.sv
// Sixteen-bit timer with capture, auto-reload and baud select over APB.
`timescale 1ns/100ps
module tcr_timer #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  input wire logic timer1_overflow,
  output logic uart_rx_baud,
  output logic uart_tx_baud,
  output logic irq
);
  if (ADDR_W < tcr_pkg::MIN_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  tcr_pin_if #(.N(tcr_pkg::NUM_PINS)) pins ();

  tcr_pin_sync #(.N(tcr_pkg::NUM_PINS)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_in({trigger_pin, count_input_pin}),
    .sync(pins)
  );

  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [7:0] control_reg, control_next;
  logic down_en_reg, down_en_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] reload_reg, reload_next;
  logic [tcr_pkg::IRQ_W-1:0] status_reg, status_next;
  logic [tcr_pkg::IRQ_W-1:0] mask_reg, mask_next;
  logic rx_baud_reg, rx_baud_next;
  logic tx_baud_reg, tx_baud_next;
  logic irq_reg, irq_next;

  logic [9:0] word;
  logic setup, wr;
  logic [31:0] rdata;
  logic mapped;
  tcr_pkg::tcr_mode_t mode;
  logic baud, tick, count_up, trig, wrap, ovf_set;
  logic ctl_wr, bit_wr, count_wr, reload_wr;
  logic [tcr_pkg::BITACC_SEL_W-1:0] bit_sel;
  logic [tcr_pkg::IRQ_W-1:0] irq_set;

  assign word = paddr[11:2];
  assign setup = psel & ~penable;
  // Writes land only at the access edge where the slave shows ready.
  assign wr = psel & penable & pready_reg & pwrite & ce;
  assign ctl_wr = wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_CONTROL);
  assign bit_wr = wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_BIT_ACCESS);
  assign count_wr = wr & (tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_LO) |
                          tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_HI));
  assign reload_wr = wr & (tcr_pkg::reg_hit(word, tcr_pkg::IDX_RELOAD_LO) |
                           tcr_pkg::reg_hit(word, tcr_pkg::IDX_RELOAD_HI));
  assign bit_sel = pwdata[tcr_pkg::BITACC_SEL_LSB +: tcr_pkg::BITACC_SEL_W];

  // Mode decode; serial baud use overrides every other mode.
  always_comb begin
    baud = control_reg[tcr_pkg::CTL_RX_CLK] |
           control_reg[tcr_pkg::CTL_TX_CLK];
    if (baud) begin
      mode = tcr_pkg::TCR_BAUD;
    end else if (control_reg[tcr_pkg::CTL_CAPTURE]) begin
      mode = tcr_pkg::TCR_CAPTURE;
    end else if (down_en_reg & control_reg[tcr_pkg::CTL_EXT_EN]) begin
      mode = tcr_pkg::TCR_UPDOWN;
    end else begin
      mode = tcr_pkg::TCR_RELOAD;
    end
  end

  always_comb begin
    tick = control_reg[tcr_pkg::CTL_RUN] &
           (control_reg[tcr_pkg::CTL_COUNTER] ?
            pins.fall[tcr_pkg::PIN_COUNT] : 1'b1);
    count_up = (mode == tcr_pkg::TCR_UPDOWN) ?
               pins.level[tcr_pkg::PIN_TRIGGER] : 1'b1;
    // In up/down the trigger pin sets direction and loads nothing.
    trig = control_reg[tcr_pkg::CTL_EXT_EN] &
           pins.fall[tcr_pkg::PIN_TRIGGER] &
           (mode == tcr_pkg::TCR_CAPTURE ||
            mode == tcr_pkg::TCR_RELOAD);
    wrap = tick & (count_up ? (count_reg == tcr_pkg::COUNT_MAX)
                            : (count_reg == reload_reg));
    ovf_set = wrap & ~baud;
    irq_set = '0;
    irq_set[tcr_pkg::IRQ_OVERFLOW] = ovf_set;
    irq_set[tcr_pkg::IRQ_EXTERNAL] = trig &
                                     (mode != tcr_pkg::TCR_UPDOWN);
  end

  // Register read mux, sampled in the setup cycle.
  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_CONTROL)) begin
      rdata[7:0] = control_reg;
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_MODE)) begin
      rdata[tcr_pkg::MODE_DOWN_EN] = down_en_reg;
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_RELOAD_LO)) begin
      rdata[7:0] = reload_reg[7:0];
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_RELOAD_HI)) begin
      rdata[7:0] = reload_reg[15:8];
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_LO)) begin
      rdata[7:0] = count_reg[7:0];
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_HI)) begin
      rdata[7:0] = count_reg[15:8];
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_IRQ_STATUS)) begin
      rdata[tcr_pkg::IRQ_W-1:0] = status_reg;
    end else if (tcr_pkg::reg_hit(word, tcr_pkg::IDX_IRQ_MASK)) begin
      rdata[tcr_pkg::IRQ_W-1:0] = mask_reg;
    end else if (!tcr_pkg::reg_hit(word, tcr_pkg::IDX_BIT_ACCESS)) begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    pready_next = setup;
    pslverr_next = setup & ~mapped;
    prdata_next = setup ? rdata : prdata_reg;
    control_next = control_reg;
    if (ctl_wr) begin
      control_next = pwdata[7:0];
    end
    if (bit_wr) begin
      control_next[bit_sel] = pwdata[tcr_pkg::BITACC_VALUE];
    end
    // Hardware sets win over a software clear in the same cycle.
    if (ovf_set) begin
      control_next[tcr_pkg::CTL_OVERFLOW] = 1'b1;
    end
    if (trig) begin
      control_next[tcr_pkg::CTL_EXTERNAL] = 1'b1;
    end
    down_en_next = down_en_reg;
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_MODE)) begin
      down_en_next = pwdata[tcr_pkg::MODE_DOWN_EN];
    end

    count_next = count_reg;
    reload_next = reload_reg;
    if (tick) begin
      if (!count_up) begin
        count_next = wrap ? tcr_pkg::COUNT_MAX
                          : count_reg - tcr_pkg::COUNT_ONE;
      end else if (!wrap) begin
        count_next = count_reg + tcr_pkg::COUNT_ONE;
      end else if (mode == tcr_pkg::TCR_CAPTURE) begin
        count_next = tcr_pkg::COUNT_WRAP;
      end else begin
        count_next = reload_reg;
      end
    end
    if (trig & (mode == tcr_pkg::TCR_RELOAD)) begin
      count_next = reload_reg;
    end
    if (trig & (mode == tcr_pkg::TCR_CAPTURE)) begin
      reload_next = count_reg;
    end
    // A software write to a byte beats the hardware update of that byte.
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_LO)) begin
      count_next[7:0] = pwdata[7:0];
    end
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_HI)) begin
      count_next[15:8] = pwdata[7:0];
    end
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_RELOAD_LO)) begin
      reload_next[7:0] = pwdata[7:0];
    end
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_RELOAD_HI)) begin
      reload_next[15:8] = pwdata[7:0];
    end

    mask_next = mask_reg;
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_IRQ_MASK)) begin
      mask_next = pwdata[tcr_pkg::IRQ_W-1:0];
    end
    status_next = status_reg;
    if (wr & tcr_pkg::reg_hit(word, tcr_pkg::IDX_IRQ_STATUS)) begin
      status_next = status_reg & ~pwdata[tcr_pkg::IRQ_W-1:0];
    end
    status_next = status_next | irq_set;
    irq_next = |(status_reg & mask_reg);
    rx_baud_next = control_reg[tcr_pkg::CTL_RX_CLK] ?
                   wrap : timer1_overflow;
    tx_baud_next = control_reg[tcr_pkg::CTL_TX_CLK] ?
                   wrap : timer1_overflow;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      control_reg <= tcr_pkg::CONTROL_RESET;
      down_en_reg <= 1'b0;
      count_reg <= tcr_pkg::COUNT_RESET;
      reload_reg <= tcr_pkg::RELOAD_RESET;
      status_reg <= '0;
      mask_reg <= '0;
      rx_baud_reg <= 1'b0;
      tx_baud_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      control_reg <= control_next;
      down_en_reg <= down_en_next;
      count_reg <= count_next;
      reload_reg <= reload_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rx_baud_reg <= rx_baud_next;
      tx_baud_reg <= tx_baud_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign uart_rx_baud = rx_baud_reg;
  assign uart_tx_baud = tx_baud_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ovf_sets_flag: assert property (ce && ovf_set |=>
    control_reg[tcr_pkg::CTL_OVERFLOW])
    else $error("overflow did not set the overflow flag");
  a_ovf_baud_block: assert property (ce && baud && !ctl_wr && !bit_wr
    |=> !$rose(control_reg[tcr_pkg::CTL_OVERFLOW]))
    else $error("overflow flag rose in baud use");
  a_ext_flag_set: assert property (ce && trig |=>
    control_reg[tcr_pkg::CTL_EXTERNAL] &&
    status_reg[tcr_pkg::IRQ_EXTERNAL])
    else $error("trigger event did not set the external flag");
  a_irq_follows: assert property (ce |=>
    irq == $past(|(status_reg & mask_reg)))
    else $error("interrupt does not follow unmasked status");
  a_ext_updown_quiet: assert property (ce && mode == tcr_pkg::TCR_UPDOWN
    |=> !$rose(status_reg[tcr_pkg::IRQ_EXTERNAL]))
    else $error("external interrupt raised in up/down mode");
  a_rx_baud_route: assert property (
    ce && control_reg[tcr_pkg::CTL_RX_CLK]
    |=> uart_rx_baud == $past(wrap))
    else $error("receive baud not taken from this timer");
  a_tx_baud_route: assert property (
    ce && !control_reg[tcr_pkg::CTL_TX_CLK]
    |=> uart_tx_baud == $past(timer1_overflow))
    else $error("transmit baud not taken from Timer 1");
  a_trig_ignored: assert property (ce && !ctl_wr && !bit_wr &&
    (!control_reg[tcr_pkg::CTL_EXT_EN] || baud)
    |=> !$rose(control_reg[tcr_pkg::CTL_EXTERNAL]))
    else $error("trigger acted while disabled");
  a_stop_holds: assert property (ce && !control_reg[tcr_pkg::CTL_RUN] &&
    !count_wr && !trig |=> count_reg == $past(count_reg))
    else $error("count moved while stopped");
  a_capture_copy: assert property (ce && trig && !reload_wr &&
    mode == tcr_pkg::TCR_CAPTURE |=> reload_reg == $past(count_reg))
    else $error("capture did not copy the count");
  a_count_low_wr: assert property (ce && wr &&
    tcr_pkg::reg_hit(word, tcr_pkg::IDX_COUNT_LO)
    |=> count_reg[7:0] == $past(pwdata[7:0]))
    else $error("count low byte write lost");
  a_bus_answer: assert property (ce && setup |=> pready ##1 !pready or
    (ce && setup))
    else $error("slave did not answer in one cycle");

  c_overflow: cover property (ce && ovf_set);
  c_capture: cover property (ce && trig && mode == tcr_pkg::TCR_CAPTURE);
  c_updown_down: cover property (ce && tick && !count_up);
  c_irq: cover property ($rose(irq));
endmodule

//--- rtl/tcr_pkg.sv
// Register map, field positions, reset values and mode codes of the timer.
package tcr_pkg;
  // Printed offsets are word indices; the byte address is four times one.
  localparam logic [9:0] IDX_CONTROL = 10'h0c8;
  localparam logic [9:0] IDX_MODE = 10'h0c9;
  localparam logic [9:0] IDX_RELOAD_LO = 10'h0ca;
  localparam logic [9:0] IDX_RELOAD_HI = 10'h0cb;
  localparam logic [9:0] IDX_COUNT_LO = 10'h0cc;
  localparam logic [9:0] IDX_COUNT_HI = 10'h0cd;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0d0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0d1;
  localparam logic [9:0] IDX_BIT_ACCESS = 10'h0d2;

  // Control, mode and interrupt register fields.
  localparam int CTL_OVERFLOW = 7;
  localparam int CTL_EXTERNAL = 6;
  localparam int CTL_RX_CLK = 5;
  localparam int CTL_TX_CLK = 4;
  localparam int CTL_EXT_EN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_COUNTER = 1;
  localparam int CTL_CAPTURE = 0;
  localparam int MODE_DOWN_EN = 0;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_EXTERNAL = 1;
  localparam int IRQ_W = 2;
  // Bit access word: bit number in the low bits, value above it.
  localparam int BITACC_SEL_LSB = 0;
  localparam int BITACC_SEL_W = 3;
  localparam int BITACC_VALUE = 8;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_WRAP = 16'h0000;

  localparam int PIN_COUNT = 0;
  localparam int PIN_TRIGGER = 1;
  localparam int NUM_PINS = 2;
  localparam int MIN_ADDR_W = 12;

  typedef enum logic [1:0] {
    TCR_CAPTURE = 2'b00,
    TCR_RELOAD = 2'b01,
    TCR_UPDOWN = 2'b10,
    TCR_BAUD = 2'b11
  } tcr_mode_t;

  function automatic logic reg_hit(logic [9:0] word, logic [9:0] idx);
    return word == idx;
  endfunction
endpackage

//--- rtl/tcr_pin_if.sv
// Synchronised pin levels and falling-edge pulses between timer modules.
`timescale 1ns/100ps
interface tcr_pin_if #(parameter int N = 2);
  logic [N-1:0] level;
  logic [N-1:0] fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

//--- rtl/tcr_pin_sync.sv
// Two-stage synchroniser and falling-edge detector for the timer pins.
`timescale 1ns/100ps
module tcr_pin_sync #(
  parameter int N = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [N-1:0] pin_in,
  tcr_pin_if.src sync
);
  logic [N-1:0] meta_reg, meta_next;
  logic [N-1:0] stab_reg, stab_next;
  logic [N-1:0] prev_reg, prev_next;

  always_comb begin
    meta_next = ce ? pin_in : meta_reg;
    stab_next = ce ? meta_reg : stab_reg;
    prev_next = ce ? stab_reg : prev_reg;
  end

  // Idle-high reset makes a pin held low at start show one falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      stab_reg <= '1;
      prev_reg <= '1;
    end else begin
      meta_reg <= meta_next;
      stab_reg <= stab_next;
      prev_reg <= prev_next;
    end
  end

  for (genvar gi = 0; gi < N; gi++) begin : g_pin
    assign sync.level[gi] = stab_reg[gi];
    assign sync.fall[gi] = prev_reg[gi] & ~stab_reg[gi];
  end
endmodule

//--- verif/tcr_serial_model.sv
// Serial port side: a Timer 1 overflow source and baud pulse counters.
`timescale 1ns/100ps
module tcr_serial_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic t1_en,
  input wire logic clr,
  input wire logic uart_rx_baud,
  input wire logic uart_tx_baud,
  output logic timer1_overflow,
  output logic [15:0] rx_n,
  output logic [15:0] tx_n,
  output logic [15:0] t1_n
);
  logic [2:0] div_reg;

  // Timer 1 pulses are gated so the bench can close a window cleanly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 3'h0;
      timer1_overflow <= 1'b0;
      rx_n <= 16'h0000;
      tx_n <= 16'h0000;
      t1_n <= 16'h0000;
    end else begin
      div_reg <= div_reg + 3'h1;
      timer1_overflow <= t1_en && div_reg == 3'h7;
      if (clr) begin
        rx_n <= 16'h0000;
        tx_n <= 16'h0000;
        t1_n <= 16'h0000;
      end else begin
        rx_n <= rx_n + {15'h0000, uart_rx_baud};
        tx_n <= tx_n + {15'h0000, uart_tx_baud};
        t1_n <= t1_n + {15'h0000, timer1_overflow};
      end
    end
  end
endmodule

//--- verif/timer2_control_and_capture_regs_test.sv
// Self-checking bench for the timer block, driven over APB.
`timescale 1ns/100ps
module timer2_control_and_capture_regs_test;
  localparam logic [9:0] CTL = tcr_pkg::IDX_CONTROL;
  localparam logic [9:0] MOD = tcr_pkg::IDX_MODE;
  localparam logic [9:0] RLO = tcr_pkg::IDX_RELOAD_LO;
  localparam logic [9:0] RHI = tcr_pkg::IDX_RELOAD_HI;
  localparam logic [9:0] CLO = tcr_pkg::IDX_COUNT_LO;
  localparam logic [9:0] CHI = tcr_pkg::IDX_COUNT_HI;
  localparam logic [9:0] STA = tcr_pkg::IDX_IRQ_STATUS;
  localparam logic [9:0] MSK = tcr_pkg::IDX_IRQ_MASK;
  localparam logic [9:0] BIT = tcr_pkg::IDX_BIT_ACCESS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic cnt_pin, trig_pin, t1_en, clr, rx_baud, tx_baud, t1_ovf, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, keep;
  logic [15:0] rx_n, tx_n, t1_n;
  logic [7:0] tctl [4] = '{8'h08, 8'h09, 8'h01, 8'h28};
  logic [7:0] tend [4] = '{8'h48, 8'h49, 8'h01, 8'h28};
  logic [7:0] trl [4] = '{8'h12, 8'h0a, 8'h12, 8'h12};
  logic [7:0] tcnt [4] = '{8'h12, 8'h0a, 8'h0a, 8'h0a};
  int mismatches, checked;

  tcr_timer #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_input_pin(cnt_pin), .trigger_pin(trig_pin),
    .timer1_overflow(t1_ovf), .uart_rx_baud(rx_baud),
    .uart_tx_baud(tx_baud), .irq(irq));
  tcr_serial_model model (.pclk(pclk), .presetn(presetn), .t1_en(t1_en),
    .clr(clr), .uart_rx_baud(rx_baud), .uart_tx_baud(tx_baud),
    .timer1_overflow(t1_ovf), .rx_n(rx_n), .tx_n(tx_n), .t1_n(t1_n));

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after an edge; leaves one idle edge so nothing is
  // assigned twice in one time step by back-to-back calls.
  task automatic xfer(input logic w, input logic [9:0] i,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 16) begin
      mismatches++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    xfer(1'b1, i, d);
  endtask

  task automatic rdc(input logic [9:0] i, input logic [31:0] exp);
    xfer(1'b0, i, 32'h0);
    chk(rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cnt_pin, trig_pin, t1_en, clr} = 4'b1100;
    ce = 1'b1;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CTL, 32'h00);
    xfer(1'b0, 10'h0ff, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(RLO, 32'h34);
    wr(RHI, 32'h12);
    wr(CHI, 32'hff);
    wr(CLO, 32'hf0);
    rdc(RLO, 32'h34);
    rdc(RHI, 32'h12);
    rdc(CHI, 32'hff);
    rdc(CLO, 32'hf0);
    wr(MSK, 32'h3);
    wr(CTL, 32'h04);
    cyc(40);
    wr(BIT, 32'h002);
    rdc(CTL, 32'h80);
    chk({31'h0, irq}, 32'h1);
    rdc(CHI, 32'h12);
    xfer(1'b0, CLO, 32'h0);
    keep = rd;
    cyc(5);
    rdc(CLO, keep);
    wr(CTL, 32'h00);
    wr(STA, 32'h3);
    rdc(CTL, 32'h00);
    chk({31'h0, irq}, 32'h0);
    $display("test overflow done");
    for (int i = 0; i < 2; i++) begin
      wr(CHI, 32'hff);
      wr(CLO, 32'hf0);
      clr <= 1'b1;
      t1_en <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      wr(CTL, i ? 32'h14 : 32'h24);
      cyc(40);
      t1_en <= 1'b0;
      wr(BIT, 32'h002);
      cyc(4);
      rdc(CTL, i ? 32'h10 : 32'h20);
      chk({31'h0, irq}, 32'h0);
      chk({16'h0, rx_n}, i ? {16'h0, t1_n} : 32'h1);
      chk({16'h0, tx_n}, i ? 32'h1 : {16'h0, t1_n});
    end
    $display("test baud done");
    for (int i = 0; i < 4; i++) begin
      wr(RLO, 32'h34);
      wr(RHI, 32'h12);
      wr(CHI, 32'h0a);
      wr(CLO, 32'hbc);
      wr(CTL, {24'h0, tctl[i]});
      trig_pin <= 1'b0;
      cyc(6);
      trig_pin <= 1'b1;
      cyc(6);
      rdc(CTL, {24'h0, tend[i]});
      rdc(RHI, {24'h0, trl[i]});
      rdc(CHI, {24'h0, tcnt[i]});
      chk({31'h0, irq}, {31'h0, tend[i][6]});
      wr(STA, 32'h3);
    end
    $display("test trigger done");
    wr(MOD, 32'h1);
    wr(CHI, 32'h30);
    wr(CLO, 32'h00);
    wr(RLO, 32'h00);
    wr(RHI, 32'h00);
    wr(CTL, 32'h0c);
    trig_pin <= 1'b0;
    cyc(20);
    wr(BIT, 32'h002);
    rdc(CHI, 32'h2f);
    rdc(CTL, 32'h08);
    chk({31'h0, irq}, 32'h0);
    trig_pin <= 1'b1;
    wr(MOD, 32'h0);
    wr(STA, 32'h3);
    $display("test updown done");
    wr(CHI, 32'h00);
    wr(CLO, 32'h00);
    wr(CTL, 32'h06);
    repeat (3) begin
      cnt_pin <= 1'b0;
      cyc(4);
      cnt_pin <= 1'b1;
      cyc(4);
    end
    cyc(4);
    wr(BIT, 32'h002);
    rdc(CLO, 32'h03);
    wr(BIT, 32'h103);
    rdc(CTL, 32'h0a);
    rdc(BIT, 32'h00);
    // A low clock enable must hold the running count still.
    wr(CLO, 32'h00);
    wr(CTL, 32'h04);
    ce <= 1'b0;
    cyc(5);
    ce <= 1'b1;
    rdc(CLO, 32'h01);
    $display("test counter done");
    end_of_test();
  end
endmodule
